/* File: mct_pkg.sv */
// Purpose: Shared constants and carriers for motor command trim and safety inputs
// Assumes: 10 MHz system clock, signed 8-bit motor commands
// Notes:   Trim gains are Q16 fractions; switch inputs read low when closed
package mct_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ            = 10000000;  // System clock rate
  localparam int unsigned INVERT_SETTLE_MS  = 500;       // Inversion switch settle time
  localparam int unsigned INVERT_SETTLE_CYC = CLK_HZ / 1000 * INVERT_SETTLE_MS;
  localparam int unsigned AUX_SETTLE_CYC    = 1;         // Aux inputs: sync only

  // Command width
  localparam int unsigned CMD_W = 8;                      // Signed speed command width
  typedef logic signed [CMD_W-1:0] mct_cmd_t;             // One channel command

  // Trim encoding and gain
  localparam logic [3:0]  TRIM_NEUTRAL   = 4'h7;          // No trim, default
  localparam logic [3:0]  TRIM_MAX       = 4'he;          // Largest legal setting
  localparam int unsigned GAIN_FRAC_BITS = 16;            // Q16 gain fraction
  localparam logic [16:0] GAIN_ONE_Q16   = 17'h10000;     // Gain of exactly one
  localparam logic [16:0] GAIN_STEP_Q16  = 17'h001ec;     // 0.75 percent of one

  // Debounce counter width, holds the longest settle count
  localparam int unsigned FILT_CNT_W = 23;

  // Switch levels: closed contact pulls the pin to ground
  localparam logic SW_CLOSED = 1'b0;                      // Contact closed
  localparam logic SW_OPEN   = 1'b1;                      // Contact open, pulled up

  // Stop-or-flip input function
  typedef enum logic [1:0] {
    MCT_SOF_NONE   = 2'h0,                                // No effect, default
    MCT_SOF_ESTOP  = 2'h1,                                // Latched emergency stop
    MCT_SOF_INVERT = 2'h2                                 // Inversion detect
  } mct_sof_func_e;

  // Auxiliary input function
  typedef enum logic [1:0] {
    MCT_AUX_IGNORE    = 2'h0,                             // Ignored, default
    MCT_AUX_ACCESSORY = 2'h1,                             // Drives accessory output
    MCT_AUX_DEADMAN   = 2'h2                              // Power stage enable
  } mct_aux_func_e;

  // Configuration carrier
  typedef struct packed {
    logic [3:0]    trim_sel;                              // Direction trim 0..14
    logic          motor_act_en;                          // Accessory follows motors
    mct_sof_func_e sof_func;                              // Stop-or-flip use
    mct_aux_func_e aux_e_func;                            // First aux input use
    mct_aux_func_e aux_f_func;                            // Second aux input use
  } mct_cfg_s;

  // Level filter state
  typedef struct packed {
    logic [FILT_CNT_W-1:0] cnt;                           // Stable time counter
    logic                  stable;                        // Accepted level
    logic                  sync2;                         // Second sync stage
    logic                  sync1;                         // First sync stage
  } mct_filt_s;

  // Main block state
  typedef struct packed {
    logic     estop_latched;                              // Stop held until reset
    logic     inverted;                                   // Command inversion active
    logic     acc_out;                                    // Accessory output
    logic     pwr_en;                                     // Power stage enable
    mct_cmd_t out_ch1;                                    // Conditioned channel 1
    mct_cmd_t out_ch2;                                    // Conditioned channel 2
  } mct_state_s;

endpackage : mct_pkg

/* File: mct_level_filter.sv */
// Purpose: Two-stage synchroniser followed by a stable-time level filter
// Assumes: Pin is asynchronous to clk_sys and idles high
// Notes:   A new level is accepted after SETTLE unchanged synchronised cycles
`timescale 1ns/1ps
module mct_level_filter import mct_pkg::*; #(
  parameter logic [FILT_CNT_W-1:0] SETTLE = FILT_CNT_W'(INVERT_SETTLE_CYC)
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Pin side
  input  wire logic pin,
  // Filtered side
  output logic      level_sync,
  output logic      level_stable
);

  mct_filt_s st_reg;   // Registered state
  mct_filt_s st_next;  // Next state

  // Filter next-state logic
  always_comb begin
    st_next       = st_reg;
    st_next.sync1 = pin;
    st_next.sync2 = st_reg.sync1;
    if (st_reg.sync2 == st_reg.stable) begin
      // Level agrees, restart the timer
      st_next.cnt = '0;
    end else if (st_reg.cnt >= SETTLE - FILT_CNT_W'(1)) begin
      // Changed level held long enough
      st_next.stable = st_reg.sync2;
      st_next.cnt    = '0;
    end else begin
      st_next.cnt = st_reg.cnt + FILT_CNT_W'(1);
    end
  end

  // State register, open switch level at reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_reg <= '{cnt: '0, stable: SW_OPEN, sync2: SW_OPEN, sync1: SW_OPEN};
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_sync   = st_reg.sync2;
  assign level_stable = st_reg.stable;

endmodule : mct_level_filter

/* File: mct_trim_gain.sv */
// Purpose: Multiplicative direction trim on one signed speed command
// Assumes: Command already passed through the selected command curve
// Notes:   Only the direction being trimmed is scaled down, never up
`timescale 1ns/1ps
module mct_trim_gain import mct_pkg::*; (
  // Command in
  input  mct_cmd_t   cmd_in,
  // Trim control
  input  wire logic [3:0] trim_sel,
  input  wire logic       bypass,
  // Command out
  output mct_cmd_t   cmd_out
);

  logic [3:0]               sel_c;    // Setting clamped to range
  logic                     pos_trim; // Positive trim selected
  logic [3:0]               steps;    // Trim steps away from neutral
  logic [16:0]              gain;     // Q16 gain
  logic [CMD_W:0]           mag;      // Command magnitude
  logic [CMD_W+17:0]        prod;     // Magnitude times gain
  logic                     reduce;   // This direction is slowed
  logic signed [CMD_W+1:0]  res;      // Signed scaled result

  // Trim arithmetic
  always_comb begin
    sel_c    = (trim_sel > TRIM_MAX) ? TRIM_MAX : trim_sel;
    pos_trim = sel_c > TRIM_NEUTRAL;
    steps    = pos_trim ? sel_c - TRIM_NEUTRAL : TRIM_NEUTRAL - sel_c;
    // True gain, not an offset
    gain     = GAIN_ONE_Q16 - 17'(17'(steps) * GAIN_STEP_Q16);
    mag      = cmd_in[CMD_W-1] ? (CMD_W+1)'(-$signed({cmd_in[CMD_W-1], cmd_in}))
                               : {1'b0, cmd_in};
    prod     = (CMD_W+18)'(mag * gain);
    // Positive trim slows reverse, negative trim slows forward
    reduce   = !bypass && (sel_c != TRIM_NEUTRAL) &&
               (pos_trim ? cmd_in[CMD_W-1] : (cmd_in > 0));
    res      = reduce ? $signed({1'b0, prod[GAIN_FRAC_BITS +: CMD_W+1]})
                      : $signed({1'b0, mag});
    if (cmd_in[CMD_W-1]) begin
      res = -res;
    end
    cmd_out  = res[CMD_W-1:0];
  end

endmodule : mct_trim_gain

/* File: mct_top.sv */
// Purpose: Command trim, accessory output and safety input logic, two channels
// Assumes: Commands arrive after the command curve; switch pins are asynchronous
// Notes:   Emergency stop clears only through rst_n
`timescale 1ns/1ps
module mct_top import mct_pkg::*; #(
  parameter logic [FILT_CNT_W-1:0] SETTLE_CYCLES = FILT_CNT_W'(INVERT_SETTLE_CYC)
) (
  // Clock and reset
  input  wire logic  clk_sys,
  input  wire logic  rst_n,
  // Configuration
  input  mct_cfg_s   cfg,
  input  wire logic  mixed_mode,
  input  wire logic  closed_loop_ch1,
  input  wire logic  closed_loop_ch2,
  input  wire logic  encoder_fitted,
  input  wire logic  accessory_cmd,
  // Commands after the command curve
  input  mct_cmd_t   cmd_ch1,
  input  mct_cmd_t   cmd_ch2,
  // Switch pins
  input  wire logic  stop_or_flip_input,
  input  wire logic  aux_e_in,
  input  wire logic  aux_f_in,
  // Conditioned commands
  output mct_cmd_t   out_ch1,
  output mct_cmd_t   out_ch2,
  // Actuators and status
  output logic       accessory_out,
  output logic       power_enable,
  output logic       estop_latched,
  output logic       inverted
);

  mct_state_s st_reg;    // Registered state
  mct_state_s st_next;   // Next state

  logic     sof_sync;    // Synchronised stop-or-flip level
  logic     sof_stable;  // Debounced stop-or-flip level
  logic     aux_e_sync;  // Synchronised first aux input
  logic     aux_f_sync;  // Synchronised second aux input
  mct_cmd_t inv_ch1;     // Channel 1 after inversion
  mct_cmd_t inv_ch2;     // Channel 2 after inversion
  mct_cmd_t trim_ch1;    // Channel 1 after trim
  mct_cmd_t trim_ch2;    // Channel 2 after trim
  logic     trim_bypass; // Any closed loop active
  logic     aux_e_live;  // First aux input usable
  logic     estop_req;   // Emergency stop requested now
  logic     deadman_ok;  // No deadman input holding power off
  logic     aux_acc;     // Aux input asks for accessory
  logic     running;     // Either motor commanded

  // Saturating negation, keeps the most negative code in range
  function automatic mct_cmd_t neg_sat(input mct_cmd_t v);
    mct_cmd_t r;
    r = (v == {1'b1, {(CMD_W-1){1'b0}}}) ? {1'b0, {(CMD_W-1){1'b1}}} : -v;
    return r;
  endfunction : neg_sat

  // Stop-or-flip: long settle for the gravity switch
  mct_level_filter #(
    .SETTLE (SETTLE_CYCLES)
  ) u_sof_filter (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .pin          (stop_or_flip_input),
    .level_sync   (sof_sync),
    .level_stable (sof_stable)
  );

  // First aux input, synchroniser only
  mct_level_filter #(
    .SETTLE (FILT_CNT_W'(AUX_SETTLE_CYC))
  ) u_aux_e_filter (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .pin          (aux_e_in),
    .level_sync   (aux_e_sync),
    .level_stable ()
  );

  // Second aux input, synchroniser only
  mct_level_filter #(
    .SETTLE (FILT_CNT_W'(AUX_SETTLE_CYC))
  ) u_aux_f_filter (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .pin          (aux_f_in),
    .level_sync   (aux_f_sync),
    .level_stable ()
  );

  // Inversion applies to both channels before trim
  always_comb begin
    inv_ch1 = st_reg.inverted ? neg_sat(cmd_ch1) : cmd_ch1;
    inv_ch2 = st_reg.inverted ? neg_sat(cmd_ch2) : cmd_ch2;
  end

  // Any closed loop channel turns trim off for both
  assign trim_bypass = closed_loop_ch1 | closed_loop_ch2;

  // Channel 1 trim
  mct_trim_gain u_trim_ch1 (
    .cmd_in   (inv_ch1),
    .trim_sel (cfg.trim_sel),
    .bypass   (trim_bypass),
    .cmd_out  (trim_ch1)
  );

  // Channel 2 trim
  mct_trim_gain u_trim_ch2 (
    .cmd_in   (inv_ch2),
    .trim_sel (cfg.trim_sel),
    .bypass   (trim_bypass),
    .cmd_out  (trim_ch2)
  );

  // Input decode
  always_comb begin
    // Encoder module takes over the first aux pin
    aux_e_live = !encoder_fitted;
    // Closed emergency contact pulls low
    estop_req  = (cfg.sof_func == MCT_SOF_ESTOP) && (sof_sync == SW_CLOSED);
    // Deadman inputs must be grounded for power
    deadman_ok = !(aux_e_live && cfg.aux_e_func == MCT_AUX_DEADMAN && aux_e_sync == SW_OPEN)
              && !(cfg.aux_f_func == MCT_AUX_DEADMAN && aux_f_sync == SW_OPEN);
    // Accessory drive while an aux input is grounded
    aux_acc    = (aux_e_live && cfg.aux_e_func == MCT_AUX_ACCESSORY
                  && aux_e_sync == SW_CLOSED)
              || (cfg.aux_f_func == MCT_AUX_ACCESSORY
                  && aux_f_sync == SW_CLOSED);
    running    = (st_reg.out_ch1 != '0) || (st_reg.out_ch2 != '0);
  end

  // Main next-state logic
  always_comb begin
    st_next = st_reg;
    // Stop latches and only reset clears it
    st_next.estop_latched = st_reg.estop_latched | estop_req;
    // Gravity switch closed means upside down
    st_next.inverted = mixed_mode && (cfg.sof_func == MCT_SOF_INVERT)
                       && (sof_stable == SW_CLOSED);
    if (st_next.estop_latched) begin
      // Halted commands
      st_next.out_ch1 = '0;
      st_next.out_ch2 = '0;
    end else begin
      st_next.out_ch1 = trim_ch1;
      st_next.out_ch2 = trim_ch2;
    end
    st_next.pwr_en  = !st_next.estop_latched && deadman_ok;
    st_next.acc_out = accessory_cmd || aux_acc
                      || (cfg.motor_act_en && running);
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_reg <= '{estop_latched: 1'b0, inverted: 1'b0, acc_out: 1'b0,
                  pwr_en: 1'b0, out_ch1: '0, out_ch2: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign out_ch1       = st_reg.out_ch1;
  assign out_ch2       = st_reg.out_ch2;
  assign accessory_out = st_reg.acc_out;
  assign power_enable  = st_reg.pwr_en;
  assign estop_latched = st_reg.estop_latched;
  assign inverted      = st_reg.inverted;

  // Checks, all in the system clock domain
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Stop request seen, then latched and held
  sequence s_stop_req;
    cfg.sof_func == MCT_SOF_ESTOP && sof_sync == SW_CLOSED;
  endsequence

  sequence s_stop_held;
    estop_latched && out_ch1 == '0 && out_ch2 == '0 && !power_enable;
  endsequence

  chk_stop_latch: assert property (s_stop_req |=> s_stop_held [*8])
    else $error("emergency stop not latched or outputs not halted");

  // Latch never drops while reset is high
  chk_stop_sticky: assert property (estop_latched |=> estop_latched)
    else $error("emergency stop released without reset");

  // Stop latch only from the stop function
  chk_sof_none: assert property (
    !estop_latched && cfg.sof_func != MCT_SOF_ESTOP |=> !estop_latched)
    else $error("stop latched while input not in stop mode");

  // Power only with no stop and no deadman release
  chk_power_gate: assert property (
    power_enable |-> !estop_latched && $past(deadman_ok))
    else $error("power enabled during stop or deadman release");

  // Deadman release on the second aux input
  sequence s_deadman_off;
    cfg.aux_f_func == MCT_AUX_DEADMAN && aux_f_in == SW_OPEN;
  endsequence

  chk_deadman_cut: assert property (
    s_deadman_off [*3] |=> !power_enable)
    else $error("power stays on with deadman input high");

  // Neutral code passes commands unchanged
  chk_trim_neutral: assert property (
    cfg.trim_sel == TRIM_NEUTRAL && !inverted && !estop_req && !estop_latched
    |=> out_ch1 == $past(cmd_ch1) && out_ch2 == $past(cmd_ch2))
    else $error("neutral trim altered a command");

  // Closed loop on channel 1 passes its command unchanged
  chk_trim_bypass: assert property (
    closed_loop_ch1 && !inverted && !estop_req && !estop_latched
    |=> out_ch1 == $past(cmd_ch1))
    else $error("trim active in closed loop");

  // Positive trim leaves forward speed alone
  chk_trim_reduce: assert property (
    !inverted && !estop_req && !estop_latched && cmd_ch1 > 0 && cfg.trim_sel > TRIM_NEUTRAL
    |=> out_ch1 == $past(cmd_ch1))
    else $error("positive trim changed forward speed");

  // Largest trim scales a reverse command by the full gain
  chk_trim_slows: assert property (
    !inverted && !estop_req && !estop_latched && !trim_bypass && cmd_ch1 == -8'sh64
    && cfg.trim_sel == TRIM_MAX |=> out_ch1 == -8'sh5e)
    else $error("full trim does not scale reverse by the expected gain");

  // Running motor turns the accessory on when enabled
  chk_motor_acc: assert property (
    cfg.motor_act_en && (out_ch1 != '0 || out_ch2 != '0) |=> accessory_out)
    else $error("accessory off while motor running");

  // Inversion needs mixed mode and the inversion function
  chk_invert_gate: assert property (
    inverted |-> $past(mixed_mode) && $past(cfg.sof_func) == MCT_SOF_INVERT)
    else $error("inversion outside mixed mode or wrong input function");

  // Encoder fitted hides the first aux input
  chk_aux_e_ignored: assert property (
    encoder_fitted && cfg.aux_f_func == MCT_AUX_IGNORE && !accessory_cmd
    && !cfg.motor_act_en |=> !accessory_out)
    else $error("first aux input used with encoder fitted");

  // Grounded accessory aux input turns the output on
  chk_acc_aux_on: assert property (
    cfg.aux_f_func == MCT_AUX_ACCESSORY && aux_f_sync == SW_CLOSED |=> accessory_out)
    else $error("accessory off with aux input grounded");

  // Aux input pulled high leaves the accessory off when nothing else asks
  chk_acc_aux_off: assert property (
    cfg.aux_f_func == MCT_AUX_ACCESSORY && aux_f_sync == SW_OPEN && !accessory_cmd
    && !cfg.motor_act_en && cfg.aux_e_func != MCT_AUX_ACCESSORY |=> !accessory_out)
    else $error("accessory on with aux input high");

  // Grounded deadman input with no stop turns the power stage on
  chk_power_on: assert property (
    cfg.aux_f_func == MCT_AUX_DEADMAN && aux_f_sync == SW_CLOSED
    && cfg.aux_e_func != MCT_AUX_DEADMAN && !estop_req && !estop_latched |=> power_enable)
    else $error("power off with deadman input grounded and no stop");

  // Inversion reverses the command when trim is neutral
  chk_invert_cmds: assert property (
    inverted && cfg.trim_sel == TRIM_NEUTRAL && !estop_req && !estop_latched
    && cmd_ch1 != {1'b1, {(CMD_W-1){1'b0}}} |=> out_ch1 == -$past(cmd_ch1))
    else $error("inversion did not reverse the command");

  // New level held off after a change; needs SETTLE_CYCLES of at least eight
  chk_sof_hold: assert property (
    $changed(sof_sync) |=> $stable(sof_stable) [*7])
    else $error("inversion level accepted before settle time");

  // No-effect function never inverts
  chk_sof_idle: assert property (cfg.sof_func == MCT_SOF_NONE |=> !inverted)
    else $error("inversion active while stop-or-flip input has no effect");

endmodule : mct_top

/* File: mct_switch_model.sv */
// Purpose: Far-side model of the switches wired to the safety and aux pins
// Assumes: Every pin has a pull-up; a closed contact shorts it to ground
// Notes:   Accessory and power stage loads are passive and not modelled
`timescale 1ns/1ps
module mct_switch_model;
  // Contact states, set by the bench
  logic sof_closed;    // Stop or gravity switch on the stop-or-flip pin
  logic aux_e_closed;  // Switch on first aux pin
  logic aux_f_closed;  // Switch on second aux pin
  // Pin levels seen by the controller
  wire logic sof_pin;
  wire logic aux_e_pin;
  wire logic aux_f_pin;

  // Open stop switch in normal use, closed to stop; open upright, closed inverted
  assign sof_pin   = sof_closed ? 1'b0 : 1'b1;
  // Aux contacts: grounded when closed, pulled high when open
  assign aux_e_pin = aux_e_closed ? 1'b0 : 1'b1;
  assign aux_f_pin = aux_f_closed ? 1'b0 : 1'b1;
endmodule : mct_switch_model

/* File: testbench.sv */
// Purpose: Self-checking bench for trim, accessory and safety input logic
// Assumes: Short settle count so the inversion filter finishes quickly
// Notes:   Switches are driven through the far-side model's contacts
`timescale 1ns/1ps
module testbench;
  import mct_pkg::*;
  localparam int SETTLE = 20;  // Shortened inversion settle count

  logic     clk_sys = 1'b0;    // 10 MHz system clock
  logic     rst_n   = 1'b0;    // Synchronous reset, held at start
  mct_cfg_s cfg     = '{4'h7, 1'b0, MCT_SOF_NONE, MCT_AUX_IGNORE, MCT_AUX_IGNORE};
  logic     mixed_mode = 1'b0, cl1 = 1'b0, cl2 = 1'b0, enc_fit = 1'b0, acc_cmd = 1'b0;
  mct_cmd_t cmd_ch1 = '0, cmd_ch2 = '0, out_ch1, out_ch2;
  logic     acc_out, pwr_en, estop, inv;
  int       errors = 0, samples_checked = 0;

  mct_switch_model sw ();

  mct_top #(.SETTLE_CYCLES(FILT_CNT_W'(SETTLE))) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .cfg(cfg), .mixed_mode(mixed_mode),
    .closed_loop_ch1(cl1), .closed_loop_ch2(cl2), .encoder_fitted(enc_fit),
    .accessory_cmd(acc_cmd), .cmd_ch1(cmd_ch1), .cmd_ch2(cmd_ch2),
    .stop_or_flip_input(sw.sof_pin), .aux_e_in(sw.aux_e_pin), .aux_f_in(sw.aux_f_pin),
    .out_ch1(out_ch1), .out_ch2(out_ch2), .accessory_out(acc_out),
    .power_enable(pwr_en), .estop_latched(estop), .inverted(inv));

  // Clock generator
  always #50 clk_sys = ~clk_sys;

  // Wait n edges, then let updates settle
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_n

  // Compare one flag
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  // Compare one command
  task automatic chk_cmd(input mct_cmd_t got, input mct_cmd_t exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cmd

  // Expected trimmed command: Q16 gain on the slowed direction only
  function automatic mct_cmd_t exp_trim(input mct_cmd_t c, input int t);
    int v, m, g;
    v = c;
    m = (v < 0) ? -v : v;
    if ((t > 7 && v < 0) || (t < 7 && v > 0)) begin
      g = 65536 - ((t > 7) ? t - 7 : 7 - t) * 492;
      m = (m * g) / 65536;
    end
    return (v < 0) ? mct_cmd_t'(-m) : mct_cmd_t'(m);
  endfunction : exp_trim

  // Apply both commands and check the registered result
  task automatic apply_cmd(input mct_cmd_t c1, input mct_cmd_t c2,
                           input mct_cmd_t e1, input mct_cmd_t e2);
    @(posedge clk_sys);
    cmd_ch1 <= c1;
    cmd_ch2 <= c2;
    wait_n(2);
    chk_cmd(out_ch1, e1);
    chk_cmd(out_ch2, e2);
  endtask : apply_cmd

  // Defaults after reset: no stop, no inversion, power on
  task automatic t_defaults();
    wait_n(3);
    chk_bit(estop, 1'b0);
    chk_bit(inv, 1'b0);
    chk_bit(acc_out, 1'b0);
    chk_bit(pwr_en, 1'b1);
  endtask : t_defaults

  // Every legal trim code 0..14 on full-scale and 100-count commands of both signs
  task automatic t_trim();
    for (int t = 0; t <= 14; t++) begin
      @(posedge clk_sys);
      cfg.trim_sel <= 4'(t);
      apply_cmd(8'sh7f, 8'sh80, exp_trim(8'sh7f, t), exp_trim(8'sh80, t));
      apply_cmd(8'sh9c, 8'sh64, exp_trim(8'sh9c, t), exp_trim(8'sh64, t));
    end
  endtask : t_trim

  // Closed loop on either channel bypasses the trim on both
  task automatic t_bypass();
    @(posedge clk_sys);
    cl1 <= 1'b1;
    apply_cmd(8'sh9c, 8'sh9c, 8'sh9c, 8'sh9c);
    @(posedge clk_sys);
    cl1 <= 1'b0;
    cl2 <= 1'b1;
    apply_cmd(8'sh9c, 8'sh9c, 8'sh9c, 8'sh9c);
    @(posedge clk_sys);
    cl2 <= 1'b0;
    apply_cmd(8'sh9c, 8'sh00, 8'sha2, 8'sh00);
    @(posedge clk_sys);
    cfg.trim_sel <= 4'h7;
  endtask : t_bypass

  // Accessory follows motor activity only when enabled
  task automatic t_motor_act();
    apply_cmd(8'sh32, 8'sh00, 8'sh32, 8'sh00);
    wait_n(3);
    chk_bit(acc_out, 1'b0);
    @(posedge clk_sys);
    cfg.motor_act_en <= 1'b1;
    wait_n(3);
    chk_bit(acc_out, 1'b1);
    apply_cmd(8'sh00, 8'sh00, 8'sh00, 8'sh00);
    wait_n(3);
    chk_bit(acc_out, 1'b0);
    @(posedge clk_sys);
    cfg.motor_act_en <= 1'b0;
    acc_cmd <= 1'b1;
    wait_n(3);
    chk_bit(acc_out, 1'b1);
    @(posedge clk_sys);
    acc_cmd <= 1'b0;
  endtask : t_motor_act

  // Aux inputs: accessory drive, encoder gating, dead-man enable
  task automatic t_aux();
    @(posedge clk_sys);
    sw.aux_f_closed <= 1'b1;
    wait_n(4);
    chk_bit(acc_out, 1'b0);
    @(posedge clk_sys);
    cfg.aux_f_func <= MCT_AUX_ACCESSORY;
    wait_n(4);
    chk_bit(acc_out, 1'b1);
    @(posedge clk_sys);
    sw.aux_f_closed <= 1'b0;
    wait_n(4);
    chk_bit(acc_out, 1'b0);
    @(posedge clk_sys);
    sw.aux_f_closed <= 1'b0;
    cfg.aux_e_func <= MCT_AUX_ACCESSORY;
    sw.aux_e_closed <= 1'b1;
    enc_fit <= 1'b1;
    wait_n(4);
    chk_bit(acc_out, 1'b0);
    @(posedge clk_sys);
    enc_fit <= 1'b0;
    wait_n(4);
    chk_bit(acc_out, 1'b1);
    @(posedge clk_sys);
    sw.aux_e_closed <= 1'b0;
    cfg.aux_e_func <= MCT_AUX_IGNORE;
    cfg.aux_f_func <= MCT_AUX_DEADMAN;
    wait_n(4);
    chk_bit(pwr_en, 1'b0);
    chk_bit(acc_out, 1'b0);
    @(posedge clk_sys);
    sw.aux_f_closed <= 1'b1;
    wait_n(4);
    chk_bit(pwr_en, 1'b1);
    @(posedge clk_sys);
    cfg.aux_f_func <= MCT_AUX_IGNORE;
    sw.aux_f_closed <= 1'b0;
  endtask : t_aux

  // Inversion: glitch rejected, settled level inverts, mixed mode needed
  task automatic t_invert();
    @(posedge clk_sys);
    cfg.sof_func <= MCT_SOF_INVERT;
    mixed_mode <= 1'b1;
    cmd_ch1 <= 8'sh64;
    sw.sof_closed <= 1'b1;
    wait_n(SETTLE - 8);
    @(posedge clk_sys);
    sw.sof_closed <= 1'b0;
    wait_n(SETTLE + 10);
    chk_bit(inv, 1'b0);
    @(posedge clk_sys);
    sw.sof_closed <= 1'b1;
    wait_n(SETTLE - 2);
    chk_bit(inv, 1'b0);
    wait_n(8);
    chk_bit(inv, 1'b1);
    chk_cmd(out_ch1, 8'sh9c);
    @(posedge clk_sys);
    mixed_mode <= 1'b0;
    wait_n(3);
    chk_bit(inv, 1'b0);
    chk_cmd(out_ch1, 8'sh64);
    @(posedge clk_sys);
    sw.sof_closed <= 1'b0;
    cfg.sof_func <= MCT_SOF_NONE;
    wait_n(SETTLE + 6);
  endtask : t_invert

  // Emergency stop: inert when unconfigured, latched until reset
  task automatic t_estop();
    @(posedge clk_sys);
    sw.sof_closed <= 1'b1;
    wait_n(5);
    chk_bit(estop, 1'b0);
    chk_cmd(out_ch1, 8'sh64);
    @(posedge clk_sys);
    sw.sof_closed <= 1'b0;
    wait_n(4);
    @(posedge clk_sys);
    cfg.sof_func <= MCT_SOF_ESTOP;
    wait_n(3);
    chk_bit(estop, 1'b0);
    @(posedge clk_sys);
    sw.sof_closed <= 1'b1;
    @(posedge clk_sys);
    sw.sof_closed <= 1'b0;
    wait_n(4);
    chk_bit(estop, 1'b1);
    chk_bit(pwr_en, 1'b0);
    chk_cmd(out_ch1, 8'sh00);
    wait_n(10);
    chk_bit(estop, 1'b1);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    wait_n(4);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_n(3);
    chk_bit(estop, 1'b0);
    chk_bit(pwr_en, 1'b1);
    chk_cmd(out_ch1, 8'sh64);
  endtask : t_estop

  // Verdict and end of run
  task automatic wrap_up();
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    sw.sof_closed = 1'b0;
    sw.aux_e_closed = 1'b0;
    sw.aux_f_closed = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_defaults();
    t_trim();
    t_bypass();
    t_motor_act();
    t_aux();
    t_invert();
    t_estop();
    wrap_up();
  end

  // Watchdog, well beyond the expected run of a few hundred cycles
  initial begin
    #(5000 * 100);
    errors++;
    wrap_up();
  end
endmodule : testbench
